// ---- common/bhc_defs.vh ----
// Constants for the Hall commutation logic
`ifndef BHC_DEFS_VH
`define BHC_DEFS_VH
// Notes on behaviour
// - Output-disable high turns every upper and lower driver off, whatever the Hall code.
// - Rotation pulse once per electrical turn, driven as an open-collector pin.
// - Rotation pulse is a buffered copy of decoded Hall channel a.
// - Codes 100, 110, 111 select U3/L1, U3/L2, U1/L2.
// - Codes 011, 001, 000 select U1/L3, U2/L3, U2/L1.
// - A phase not in the current step has both its drivers off.
// Hall code, bit 2 is channel a, bit 0 is channel c
`define BHC_CODE_100 3'h4
`define BHC_CODE_110 3'h6
`define BHC_CODE_111 3'h7
`define BHC_CODE_011 3'h3
`define BHC_CODE_001 3'h1
`define BHC_CODE_000 3'h0
// Drive pattern {high3,high2,high1,low3,low2,low1}
`define BHC_PAT_U3L1 6'h21
`define BHC_PAT_U3L2 6'h22
`define BHC_PAT_U1L2 6'h0a
`define BHC_PAT_U1L3 6'h0c
`define BHC_PAT_U2L3 6'h14
`define BHC_PAT_U2L1 6'h11
`define BHC_PAT_OFF 6'h00
`define BHC_HALL_A 2
// Input word position of the disable bit, and the reset word that holds it set
`define BHC_IN_DIS 3
`define BHC_SYNC_RST 4'h8
// Pattern layout: lower drivers at bits 2:0, upper drivers from bit 3
`define BHC_PHASES 3
`define BHC_HIGH_LSB 3
// Reset levels of the driver enables and the rotation pulse pin
`define BHC_DRIVE_OFF 1'b0
`define BHC_PIN_DATA 1'b0
`define BHC_PULL_RST 1'b1
`endif

// ---- rtl/bhc_commutation.v ----
// Hall-sensor decode to six-step phase driver enables
`timescale 1ns/1ps
`default_nettype none
`include "bhc_defs.vh"
module bhc_commutation (
    input wire clk_i, // 250 MHz clock
    input wire nrst_i, // Async reset, active low
    input wire ce_i, // Clock enable, freezes state when low
    input wire hall_sense_a_i, // Hall channel a, 1 = positive differential
    input wire hall_sense_b_i, // Hall channel b
    input wire hall_sense_c_i, // Hall channel c
    input wire out_disable_i, // High: all phases high impedance
    output reg high_side_drive_1_o, // Upper driver phase 1
    output reg high_side_drive_2_o, // Upper driver phase 2
    output reg high_side_drive_3_o, // Upper driver phase 3
    output reg low_side_drive_1_o, // Lower driver phase 1
    output reg low_side_drive_2_o, // Lower driver phase 2
    output reg low_side_drive_3_o, // Lower driver phase 3
    output reg rot_pulse_o, // Rotation pulse pin data level (always low)
    output reg rot_pulse_oe_o // Open-collector pull-down enable
);
    // Reset word keeps the disable bit set until real inputs have passed the filter
    localparam [`BHC_IN_DIS:0] SYNC_INIT = `BHC_SYNC_RST;

    // Input word: bits 2:0 carry Hall a..c, the top bit carries the disable
    wire [`BHC_IN_DIS:0] raw_in;
    wire [`BHC_IN_DIS:0] stable;
    wire [`BHC_HALL_A:0] code;
    wire dis;
    reg [5:0] dec_pat;
    reg [5:0] next_pat;
    wire [`BHC_PHASES-1:0] next_high;
    wire [`BHC_PHASES-1:0] next_low;
    wire next_pull;
    genvar g;
    genvar p;

    assign raw_in = {out_disable_i, hall_sense_a_i, hall_sense_b_i, hall_sense_c_i};
    assign code = stable[`BHC_HALL_A:0];
    assign dis = stable[`BHC_IN_DIS];
    assign next_pull = ~code[`BHC_HALL_A];

    // One filter per input; a level is taken once stages two and three agree
    generate
        for (g = 0; g <= `BHC_IN_DIS; g = g + 1)
        begin : gen_sync
            reg stage1;
            reg stage2;
            reg stage3;
            reg held;

            always @(posedge clk_i or negedge nrst_i)
            begin
                if (!nrst_i)
                begin
                    stage1 <= SYNC_INIT[g];
                    stage2 <= SYNC_INIT[g];
                    stage3 <= SYNC_INIT[g];
                    held <= SYNC_INIT[g];
                end
                else if (ce_i)
                begin
                    stage1 <= raw_in[g];
                    stage2 <= stage1;
                    stage3 <= stage2;
                    if (stage2 == stage3)
                    begin
                        held <= stage3;
                    end
                end
            end
            assign stable[g] = held;
        end
    endgenerate

    always @*
    begin
        dec_pat = `BHC_PAT_OFF;
        case (code)
            `BHC_CODE_100:
            begin
                dec_pat = `BHC_PAT_U3L1;
            end
            `BHC_CODE_110:
            begin
                dec_pat = `BHC_PAT_U3L2;
            end
            `BHC_CODE_111:
            begin
                dec_pat = `BHC_PAT_U1L2;
            end
            `BHC_CODE_011:
            begin
                dec_pat = `BHC_PAT_U1L3;
            end
            `BHC_CODE_001:
            begin
                dec_pat = `BHC_PAT_U2L3;
            end
            `BHC_CODE_000:
            begin
                dec_pat = `BHC_PAT_U2L1;
            end
            default:
            begin
                dec_pat = `BHC_PAT_OFF;
            end
        endcase
    end

    // Disable wins over any Hall code
    always @*
    begin
        if (dis)
        begin
            next_pat = `BHC_PAT_OFF;
        end
        else
        begin
            next_pat = dec_pat;
        end
    end

    // Guard each phase: never both drivers on, an idle phase floats
    generate
        for (p = 0; p < `BHC_PHASES; p = p + 1)
        begin : gen_phase
            assign next_high[p] = next_pat[`BHC_HIGH_LSB + p] & ~next_pat[p];
            assign next_low[p] = next_pat[p] & ~next_pat[`BHC_HIGH_LSB + p];
        end
    endgenerate

    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            high_side_drive_1_o <= `BHC_DRIVE_OFF;
        end
        else if (ce_i)
        begin
            high_side_drive_1_o <= next_high[0];
        end
    end

    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            high_side_drive_2_o <= `BHC_DRIVE_OFF;
        end
        else if (ce_i)
        begin
            high_side_drive_2_o <= next_high[1];
        end
    end

    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            high_side_drive_3_o <= `BHC_DRIVE_OFF;
        end
        else if (ce_i)
        begin
            high_side_drive_3_o <= next_high[2];
        end
    end

    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            low_side_drive_1_o <= `BHC_DRIVE_OFF;
        end
        else if (ce_i)
        begin
            low_side_drive_1_o <= next_low[0];
        end
    end

    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            low_side_drive_2_o <= `BHC_DRIVE_OFF;
        end
        else if (ce_i)
        begin
            low_side_drive_2_o <= next_low[1];
        end
    end

    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            low_side_drive_3_o <= `BHC_DRIVE_OFF;
        end
        else if (ce_i)
        begin
            low_side_drive_3_o <= next_low[2];
        end
    end

    // Open collector: the data level is always low, only the pull-down enable moves
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rot_pulse_o <= `BHC_PIN_DATA;
        end
        else if (ce_i)
        begin
            rot_pulse_o <= `BHC_PIN_DATA;
        end
    end

    // Pull low while channel a is low, release when high
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rot_pulse_oe_o <= `BHC_PULL_RST;
        end
        else if (ce_i)
        begin
            rot_pulse_oe_o <= next_pull;
        end
    end
endmodule // bhc_commutation
`default_nettype wire

// ---- test/bhc_props.sv ----
// Concurrent checks on the commutation outputs
`timescale 1ns/1ps
`default_nettype none
module bhc_props (
    input wire logic clk_i, // Clock
    input wire logic nrst_i, // Async reset, active low
    input wire logic ce_i, // Clock enable
    input wire logic out_disable_i, // Output disable
    input wire logic rot_pulse_o, // Rotation pulse data level
    input wire logic rot_pulse_oe_o, // Rotation pulse pull-down enable
    input wire logic hall_sense_a_i, // Hall channel a
    input wire logic hall_sense_b_i, // Hall channel b
    input wire logic hall_sense_c_i, // Hall channel c
    input wire logic high_side_drive_1_o, // Upper driver phase 1
    input wire logic high_side_drive_2_o, // Upper driver phase 2
    input wire logic high_side_drive_3_o, // Upper driver phase 3
    input wire logic low_side_drive_1_o, // Lower driver phase 1
    input wire logic low_side_drive_2_o, // Lower driver phase 2
    input wire logic low_side_drive_3_o // Lower driver phase 3
);
    wire [2:0] c = {hall_sense_a_i, hall_sense_b_i, hall_sense_c_i};
    wire [5:0] d = {high_side_drive_3_o, high_side_drive_2_o, high_side_drive_1_o,
        low_side_drive_3_o, low_side_drive_2_o, low_side_drive_1_o};
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    sequence s_calm;
        (ce_i && $stable(c) && $stable(out_disable_i))[*7];
    endsequence
    a_disable_all_off: assert property ((out_disable_i && ce_i)[*6] |-> d == 0)
        else $error("drive while disabled");
    a_upper_a_steps: assert property (s_calm ##0 (!out_disable_i && c[2] && c != 3'h5)
        |-> d == (c == 3'h4 ? 6'h21 : c == 3'h6 ? 6'h22 : 6'h0a)) else $error("a-high step");
    a_lower_a_steps: assert property (s_calm ##0 (!out_disable_i && !c[2] && c != 3'h2)
        |-> d == (c == 3'h3 ? 6'h0c : c == 3'h1 ? 6'h14 : 6'h11)) else $error("a-low step");
    a_unused_off: assert property (s_calm ##0 (c == 3'h2 || c == 3'h5) |-> d == 0)
        else $error("unused code drives");
    a_phase_float: assert property ($countones(d) <= 2 && (d[5:3] & d[2:0]) == 0)
        else $error("phase not floated");
    a_pulse_copy: assert property (s_calm |-> rot_pulse_oe_o == !hall_sense_a_i)
        else $error("pulse not copy of a");
    a_pulse_oc: assert property (rot_pulse_o == 1'b0) else $error("pulse pin driven high");
endmodule // bhc_props
bind bhc_commutation bhc_props u_props (.*);
`default_nettype wire

// ---- test/bhc_hall_model.sv ----
// Hall sensor model stepping the forward six-step code
`timescale 1ns/1ps
`default_nettype none
module bhc_hall_model (
    input wire logic clk_i, // Clock
    input wire logic step_i, // Advance one step
    input wire logic [3:0] frc_i, // Bit 3 set: present bits 2:0
    output logic [2:0] hall_o // Code {a,b,c}
);
    logic [2:0] ph = 3'h0;
    wire [17:0] seq = 18'h26ec8;
    always @(posedge clk_i) if (step_i) ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
    assign hall_o = frc_i[3] ? frc_i[2:0] : seq[5'd15 - 5'd3 * ph +: 3];
endmodule // bhc_hall_model
`default_nettype wire

// ---- test/bldc_hall_commutation_logic_bench.sv ----
// Self-checking bench for the Hall commutation logic
`timescale 1ns/1ps
`default_nettype none
module bldc_hall_commutation_logic_bench;
    logic clk_i = 0, nrst_i = 0, ce_i = 0, dis = 1, step = 0;
    logic [3:0] frc = 4'h0;
    logic [2:0] h;
    wire [7:0] d;
    int bad_count = 0, n_checks = 0, seed = 32'h9d57fb3c;
    bhc_hall_model hm_u (.clk_i(clk_i), .step_i(step), .frc_i(frc), .hall_o(h));
    bhc_commutation dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .hall_sense_a_i(h[2]),
        .hall_sense_b_i(h[1]), .hall_sense_c_i(h[0]), .out_disable_i(dis),
        .high_side_drive_3_o(d[5]), .high_side_drive_2_o(d[4]), .high_side_drive_1_o(d[3]),
        .low_side_drive_3_o(d[2]), .low_side_drive_2_o(d[1]), .low_side_drive_1_o(d[0]),
        .rot_pulse_o(d[7]), .rot_pulse_oe_o(d[6]));
    initial forever #2 clk_i = ~clk_i;
    // Expected {pin data, pull-down, six drives} for a code
    function automatic [7:0] f(input [2:0] c, input x);
        logic [47:0] t;
        t = 48'h2a2021300511;
        return {1'b0, !c[2], x ? 6'h00 : t[c * 6 +: 6]};
    endfunction
    task automatic chk(input [7:0] s, e);
        n_checks++;
        if (s !== e) bad_count++;
        if (s !== e) $display("unexpected drive exp %h seen %h", e, s);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(negedge clk_i);
        nrst_i = 1;
        ce_i = 1;
        for (int i = 0; i < 16; i++)
        begin
            frc = {1'b1, i[2:0]};
            dis = i[3];
            repeat (7) @(negedge clk_i);
            chk(d, f(h, dis));
        end
        frc = 4'h0;
        for (int i = 0; i < 30; i++)
        begin
            step = 1;
            dis = ($random(seed) % 4) == 0;
            @(negedge clk_i);
            step = 0;
            repeat (6 + {$random(seed)} % 8) @(negedge clk_i);
            chk(d, f(h, dis));
        end
        // Clock enable low freezes the outputs, then they catch up
        frc = 4'hc;
        dis = 0;
        repeat (7) @(negedge clk_i);
        ce_i = 0;
        frc = 4'hb;
        repeat (8) @(negedge clk_i);
        chk(d, f(3'h4, 1'b0));
        ce_i = 1;
        repeat (7) @(negedge clk_i);
        chk(d, f(3'h3, 1'b0));
        // Reset in mid-run: drivers off and pin pulled low until inputs pass the filter
        nrst_i = 0;
        @(negedge clk_i);
        chk(d, 8'h40);
        nrst_i = 1;
        @(negedge clk_i);
        chk(d, 8'h40);
        repeat (6) @(negedge clk_i);
        chk(d, f(3'h3, 1'b0));
        test_done();
    end
endmodule // bldc_hall_commutation_logic_bench
`default_nettype wire
